//--- design/hpb_host_port.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - chip select low active, polarity from config
// - only pointer port (cmd 0), data port (cmd 1)
// - dummy memory command loads the internal buffer
// - address steps by bus width, then prefetch
// - 16K memory, 3K transmit, 13K receive
// - write wraps to 0 at 3K
// - read wraps to 0C00h at 16K
// - two transmit slots used alternately
// - control at 02h, slot status 03h/04h
// - reset: transmit start 00h, first slot
// - second length may be written once first send starts (length copied at start)
// - receive ring starts at 0C00h after reset
// - 4-byte header 01h, status, length low/high
// - packet start aligned to bus width
module hpb_host_port #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cs_pin_i,
  input wire logic cs_pol_i,
  input wire logic cmd_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic mode16_i,
  input wire logic [15:0] sd_i,
  output logic [15:0] sd_o,
  output logic sd_oe_o,
  input wire logic rx_valid_i,
  input wire hpb_pkg::hpb_rx_word_t rx_word_i,
  output logic rx_ready_o,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic tx_last_o,
  input wire logic tx_ready_i,
  output logic [7:0] tx_ctrl_o,
  input wire logic tx_done_i,
  input wire logic [7:0] tx_status_i
);
  typedef enum logic [1:0] {TX_IDLE, TX_RUN, TX_WAIT} hpb_tx_state_t;
  typedef enum logic {RX_DATA, RX_HDR} hpb_rx_state_t;

  hpb_pkg::hpb_pins_t s1_reg, s2_reg, s3_reg, f_reg, f_next;
  logic cs_act, rd_act, wr_act, rd_q_reg, wr_q_reg, rd_go, wr_go;
  logic h_wr_data, h_mem_wr, h_mem_rd;
  logic [1:0] step;
  logic [7:0] idx_reg, imr_reg, txc_reg, txs1_reg, txs2_reg;
  logic [15:0] len_reg, mbuf_reg, rdata, sd_reg;
  logic sd_oe_reg;
  logic [13:0] maddr_reg, ma1;
  logic [7:0] pmem [hpb_pkg::MEM_BYTES];
  hpb_tx_state_t tx_state;
  logic [13:0] tx_addr_reg, tx_base_reg;
  logic [15:0] tx_rem_reg;
  logic tx_valid_reg, tx_last_reg, tx_slot_reg, tx_done_go;
  logic [7:0] tx_data_reg;
  hpb_rx_state_t rx_state;
  logic [13:0] rxwp_reg, rx_addr_reg, rx_waddr, rx_al;
  logic [15:0] rx_len_reg;
  logic [7:0] rx_stat_reg, rx_wdata;
  logic [1:0] hdr_cnt_reg;
  logic rx_we, fo_valid, fo_ready;
  hpb_pkg::hpb_rx_word_t fo_word;

  // memory address step with optional wrap inside the tx or rx area
  function automatic logic [13:0] adv_addr(input logic [13:0] a, input logic [1:0] st,
                                           input logic wr, input logic wrap);
    logic [14:0] n;
    n = {1'h0, a} + {13'h0000, st};
    if (wrap && wr && n >= {1'h0, hpb_pkg::TX_END}) adv_addr = 14'h0000;
    else if (wrap && !wr && n[14]) adv_addr = hpb_pkg::RX_BASE;
    else adv_addr = n[13:0];
  endfunction : adv_addr

  // receive ring addition, folds past the top back to the ring base
  function automatic logic [13:0] ring_add(input logic [13:0] a, input logic [2:0] k);
    logic [14:0] s;
    s = {1'h0, a} + {12'h000, k};
    ring_add = s[14] ? s[13:0] + hpb_pkg::RX_BASE : s[13:0];
  endfunction : ring_add

  // three-stage pin synchroniser, change accepted once stages two and three agree
  always_comb f_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & f_reg);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg <= hpb_pkg::PINS_RST;
      s2_reg <= hpb_pkg::PINS_RST;
      s3_reg <= hpb_pkg::PINS_RST;
      f_reg <= hpb_pkg::PINS_RST;
    end else begin
      s1_reg <= {cs_pin_i, cmd_i, rd_n_i, wr_n_i, cs_pol_i, mode16_i, sd_i};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      f_reg <= f_next;
    end
  end

  assign cs_act = ~(f_reg.cs ^ f_reg.pol);
  assign rd_act = cs_act && !f_reg.rd_n;
  assign wr_act = cs_act && !f_reg.wr_n;
  assign rd_go = rd_act && !rd_q_reg;
  assign wr_go = wr_act && !wr_q_reg;
  assign h_wr_data = wr_go && f_reg.cmd;
  assign h_mem_wr = h_wr_data && idx_reg == hpb_pkg::IDX_MEM_WR;
  assign h_mem_rd = rd_go && f_reg.cmd && idx_reg == hpb_pkg::IDX_MEM_RD;
  assign step = f_reg.m16 ? 2'h2 : 2'h1;
  assign ma1 = maddr_reg + 14'h0001;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_q_reg <= 1'h0;
      wr_q_reg <= 1'h0;
    end else begin
      rd_q_reg <= rd_act;
      wr_q_reg <= wr_act;
    end
  end

  // pointer port: only a cmd 0 write changes it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) idx_reg <= 8'h00;
    else if (wr_go && !f_reg.cmd) idx_reg <= f_reg.data[7:0];
  end

  // host-written configuration; start bit set wins over completion clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      imr_reg <= hpb_pkg::IMR_RST;
      txc_reg <= hpb_pkg::TXC_RST;
      len_reg <= 16'h0000;
    end else begin
      if (h_wr_data && idx_reg == hpb_pkg::IDX_IMR) imr_reg <= f_reg.data[7:0];
      if (h_wr_data && idx_reg == hpb_pkg::IDX_TX_LEN_LO) len_reg[7:0] <= f_reg.data[7:0];
      if (h_wr_data && idx_reg == hpb_pkg::IDX_TX_LEN_HI) len_reg[15:8] <= f_reg.data[7:0];
      if (h_wr_data && idx_reg == hpb_pkg::IDX_TX_CTRL)
        txc_reg <= f_reg.data[7:0] | (txc_reg & hpb_pkg::TXC_START_MASK);
      else if (tx_done_go) txc_reg[hpb_pkg::TXC_START_BIT] <= 1'h0;
    end
  end
  assign tx_ctrl_o = txc_reg;

  // memory address and read buffer; each read returns the buffer then prefetches
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      maddr_reg <= hpb_pkg::MADDR_RST;
      mbuf_reg <= 16'h0000;
    end else begin
      if (h_wr_data && idx_reg == hpb_pkg::IDX_MADDR_LO) maddr_reg[7:0] <= f_reg.data[7:0];
      else if (h_wr_data && idx_reg == hpb_pkg::IDX_MADDR_HI)
        maddr_reg[13:8] <= f_reg.data[5:0];
      else if (h_mem_rd) begin
        mbuf_reg <= {pmem[ma1], pmem[maddr_reg]};
        maddr_reg <= adv_addr(maddr_reg, step, 1'h0, imr_reg[hpb_pkg::IMR_WRAP_BIT]);
      end else if (h_mem_wr)
        maddr_reg <= adv_addr(maddr_reg, step, 1'h1, imr_reg[hpb_pkg::IMR_WRAP_BIT]);
    end
  end

  // single write port; host writes take the slot, receive writer stalls
  always_ff @(posedge clk_i) begin
    if (h_mem_wr) begin
      pmem[maddr_reg] <= f_reg.data[7:0];
      if (f_reg.m16) pmem[ma1] <= f_reg.data[15:8];
    end else if (rx_we) pmem[rx_waddr] <= rx_wdata;
  end

  always_comb begin
    rdata = 16'h0000;
    unique case (idx_reg)
      hpb_pkg::IDX_MEM_RD: rdata = f_reg.m16 ? mbuf_reg : {8'h00, mbuf_reg[7:0]};
      hpb_pkg::IDX_TX_CTRL: rdata[7:0] = txc_reg;
      hpb_pkg::IDX_TX_STAT1: rdata[7:0] = txs1_reg;
      hpb_pkg::IDX_TX_STAT2: rdata[7:0] = txs2_reg;
      hpb_pkg::IDX_TX_LEN_LO: rdata[7:0] = len_reg[7:0];
      hpb_pkg::IDX_TX_LEN_HI: rdata[7:0] = len_reg[15:8];
      hpb_pkg::IDX_IMR: rdata[7:0] = imr_reg;
      hpb_pkg::IDX_MADDR_LO: rdata[7:0] = maddr_reg[7:0];
      hpb_pkg::IDX_MADDR_HI: rdata[5:0] = maddr_reg[13:8];
      hpb_pkg::IDX_RXPTR_LO: rdata[7:0] = rxwp_reg[7:0];
      hpb_pkg::IDX_RXPTR_HI: rdata[5:0] = rxwp_reg[13:8];
      default: rdata = 16'h0000;
    endcase
  end

  // read data launched at the strobe's leading edge, held until the next read
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sd_reg <= 16'h0000;
      sd_oe_reg <= 1'h0;
    end else begin
      sd_oe_reg <= rd_act;
      if (rd_go) sd_reg <= f_reg.cmd ? rdata : {8'h00, idx_reg};
    end
  end
  assign sd_o = sd_reg;
  assign sd_oe_o = sd_oe_reg;

  // transmit slots; tx area always wraps at its end regardless of the mask bit
  assign tx_done_go = tx_state == TX_WAIT && tx_done_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_state <= TX_IDLE;
      tx_addr_reg <= hpb_pkg::TX_BASE_RST;
      tx_base_reg <= hpb_pkg::TX_BASE_RST;
      tx_slot_reg <= 1'h0;
      tx_rem_reg <= 16'h0000;
      tx_valid_reg <= 1'h0;
      tx_last_reg <= 1'h0;
      tx_data_reg <= 8'h00;
      txs1_reg <= 8'h00;
      txs2_reg <= 8'h00;
    end else begin
      unique case (tx_state)
        TX_IDLE: if (txc_reg[hpb_pkg::TXC_START_BIT]) begin
          tx_addr_reg <= tx_base_reg;
          tx_rem_reg <= len_reg;
          tx_state <= TX_RUN;
        end
        TX_RUN: if (!tx_valid_reg || tx_ready_i) begin
          if (tx_rem_reg != 16'h0000) begin
            tx_valid_reg <= 1'h1;
            tx_data_reg <= pmem[tx_addr_reg];
            tx_last_reg <= tx_rem_reg == 16'h0001;
            tx_addr_reg <= adv_addr(tx_addr_reg, 2'h1, 1'h1, 1'h1);
            tx_rem_reg <= tx_rem_reg - 16'h0001;
          end else begin
            tx_valid_reg <= 1'h0;
            tx_last_reg <= 1'h0;
            tx_state <= TX_WAIT;
          end
        end
        TX_WAIT: if (tx_done_i) begin
          if (tx_slot_reg) txs2_reg <= tx_status_i;
          else txs1_reg <= tx_status_i;
          tx_slot_reg <= ~tx_slot_reg;
          tx_base_reg <= tx_addr_reg;
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end
  assign tx_valid_o = tx_valid_reg;
  assign tx_data_o = tx_data_reg;
  assign tx_last_o = tx_last_reg;

  // receive path: fifo absorbs bursts while the host owns the write port
  hpb_fifo #(
    .WIDTH($bits(hpb_pkg::hpb_rx_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_hpb_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(rx_valid_i),
    .in_ready_o(rx_ready_o),
    .in_data_i(rx_word_i),
    .out_valid_o(fo_valid),
    .out_ready_i(fo_ready),
    .out_data_o(fo_word)
  );

  assign fo_ready = rx_state == RX_DATA && !h_mem_wr;
  assign rx_al = ring_add(rx_addr_reg, {2'h0, f_reg.m16 & rx_addr_reg[0]});

  // no overrun check against the host read side: software must keep up
  always_comb begin
    rx_we = 1'h0;
    rx_waddr = rx_addr_reg;
    rx_wdata = fo_word.data;
    if (rx_state == RX_DATA) rx_we = fo_valid && fo_ready;
    else if (!h_mem_wr) begin
      rx_we = 1'h1;
      rx_waddr = ring_add(rxwp_reg, {1'h0, hdr_cnt_reg});
      unique case (hdr_cnt_reg)
        2'h0: rx_wdata = hpb_pkg::RX_HDR_MARK;
        2'h1: rx_wdata = rx_stat_reg;
        2'h2: rx_wdata = rx_len_reg[7:0];
        2'h3: rx_wdata = rx_len_reg[15:8];
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_state <= RX_DATA;
      rxwp_reg <= hpb_pkg::RX_BASE;
      rx_addr_reg <= hpb_pkg::RX_FIRST;
      rx_len_reg <= 16'h0000;
      rx_stat_reg <= 8'h00;
      hdr_cnt_reg <= 2'h0;
    end else begin
      unique case (rx_state)
        RX_DATA: if (rx_we) begin
          rx_addr_reg <= ring_add(rx_addr_reg, 3'h1);
          rx_len_reg <= rx_len_reg + 16'h0001;
          if (fo_word.last) begin
            rx_stat_reg <= fo_word.status;
            hdr_cnt_reg <= 2'h0;
            rx_state <= RX_HDR;
          end
        end
        RX_HDR: if (rx_we) begin
          hdr_cnt_reg <= hdr_cnt_reg + 2'h1;
          if (hdr_cnt_reg == 2'h3) begin
            rxwp_reg <= rx_al;
            rx_addr_reg <= ring_add(rx_al, hpb_pkg::RX_HDR_BYTES);
            rx_len_reg <= 16'h0000;
            rx_state <= RX_DATA;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence tx_launch_s;
    tx_state == TX_IDLE && txc_reg[hpb_pkg::TXC_START_BIT];
  endsequence
  sequence tx_first_s;
    tx_state == TX_RUN && tx_rem_reg == $past(len_reg);
  endsequence

  cs_gate_a: assert property (wr_go |-> (f_reg.cs == f_reg.pol))
    else $error("write taken with chip select inactive");
  idx_hold_a: assert property (!(wr_go && !f_reg.cmd) |=> $stable(idx_reg))
    else $error("pointer changed without pointer write");
  idx_load_a: assert property (wr_go && !f_reg.cmd |=> idx_reg == $past(f_reg.data[7:0]))
    else $error("pointer write not stored");
  rd_buf_a: assert property (h_mem_rd |=> mbuf_reg[7:0] == $past(pmem[maddr_reg]))
    else $error("prefetch buffer not loaded");
  addr_step_a: assert property ((h_mem_rd || h_mem_wr) && !imr_reg[7]
    && maddr_reg < 14'h3F00
    |=> maddr_reg == $past(maddr_reg) + ($past(f_reg.m16) ? 14'h0002 : 14'h0001))
    else $error("address step wrong");
  wr_wrap_a: assert property (h_mem_wr && imr_reg[7]
    && maddr_reg == (f_reg.m16 ? 14'h0BFE : 14'h0BFF) |=> maddr_reg == 14'h0000)
    else $error("write wrap missed");
  rd_wrap_a: assert property (h_mem_rd && imr_reg[7]
    && maddr_reg == (f_reg.m16 ? 14'h3FFE : 14'h3FFF) |=> maddr_reg == hpb_pkg::RX_BASE)
    else $error("read wrap missed");
  tx_start_a: assert property (tx_launch_s
    |=> tx_first_s ##0 tx_addr_reg == $past(tx_base_reg))
    else $error("transmit did not start at slot base");
  slot_alt_a: assert property (tx_done_go |=> tx_slot_reg != $past(tx_slot_reg))
    else $error("slot did not alternate");
  slot_stat_a: assert property (tx_done_go && !tx_slot_reg
    |=> txs1_reg == $past(tx_status_i))
    else $error("first slot status lost");
  rx_area_a: assert property (rx_we |-> rx_waddr >= hpb_pkg::RX_BASE)
    else $error("receive write outside ring");
  hdr_mark_a: assert property (rx_state == RX_HDR && hdr_cnt_reg == 2'h0 && rx_we
    |-> rx_wdata == hpb_pkg::RX_HDR_MARK)
    else $error("header mark wrong");
  rx_align_a: assert property (rx_state == RX_HDR && hdr_cnt_reg == 2'h3 && rx_we
    && f_reg.m16 |=> !rxwp_reg[0])
    else $error("packet start not word aligned");
endmodule : hpb_host_port
`default_nettype wire

//--- design/hpb_pkg.sv
package hpb_pkg;
  localparam int unsigned MEM_BYTES = 16384;
  localparam int unsigned MEM_AW = 14;

  // register-pointer values reached through the data port
  localparam logic [7:0] IDX_TX_CTRL = 8'h02;
  localparam logic [7:0] IDX_TX_STAT1 = 8'h03;
  localparam logic [7:0] IDX_TX_STAT2 = 8'h04;
  localparam logic [7:0] IDX_MEM_RD = 8'hF2;
  localparam logic [7:0] IDX_MADDR_LO = 8'hF4;
  localparam logic [7:0] IDX_MADDR_HI = 8'hF5;
  localparam logic [7:0] IDX_RXPTR_LO = 8'hF6;
  localparam logic [7:0] IDX_RXPTR_HI = 8'hF7;
  localparam logic [7:0] IDX_MEM_WR = 8'hF8;
  localparam logic [7:0] IDX_TX_LEN_LO = 8'hFC;
  localparam logic [7:0] IDX_TX_LEN_HI = 8'hFD;
  localparam logic [7:0] IDX_IMR = 8'hFE;

  // field positions
  localparam int unsigned IMR_WRAP_BIT = 7;
  localparam int unsigned TXC_START_BIT = 1;
  localparam logic [7:0] TXC_START_MASK = 8'h02;

  // memory layout and reset values
  localparam logic [13:0] TX_END = 14'h0C00;
  localparam logic [13:0] RX_BASE = 14'h0C00;
  localparam logic [13:0] RX_FIRST = 14'h0C04;
  localparam logic [13:0] TX_BASE_RST = 14'h0000;
  localparam logic [13:0] MADDR_RST = 14'h0000;
  localparam logic [7:0] IMR_RST = 8'h00;
  localparam logic [7:0] TXC_RST = 8'h00;
  localparam logic [7:0] RX_HDR_MARK = 8'h01;
  localparam logic [2:0] RX_HDR_BYTES = 3'h4;

  typedef struct packed {
    logic last;
    logic [7:0] status;
    logic [7:0] data;
  } hpb_rx_word_t;

  typedef struct packed {
    logic cs;
    logic cmd;
    logic rd_n;
    logic wr_n;
    logic pol;
    logic m16;
    logic [15:0] data;
  } hpb_pins_t;

  // idle bus: select high, both strobes high
  localparam hpb_pins_t PINS_RST = {1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 16'h0000};
endpackage : hpb_pkg

//--- design/hpb_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module hpb_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output var logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  logic [AW:0] cnt_next;
  logic push;
  logic pop;

  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_valid_o = cnt_reg != '0;
  assign out_data_o = mem[rp_reg];

  always_comb begin
    unique case ({push, pop})
      2'h2: cnt_next = cnt_reg + 1'h1;
      2'h1: cnt_next = cnt_reg - 1'h1;
      default: cnt_next = cnt_reg;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (push) mem[wp_reg] <= in_data_i;
  end

  // ready is registered so a full fifo stalls the source cleanly
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      in_ready_o <= 1'h1;
    end else begin
      if (push) wp_reg <= (wp_reg == LAST) ? '0 : wp_reg + 1'h1;
      if (pop) rp_reg <= (rp_reg == LAST) ? '0 : rp_reg + 1'h1;
      cnt_reg <= cnt_next;
      in_ready_o <= cnt_next != FULL;
    end
  end
endmodule : hpb_fifo
`default_nettype wire

//--- verification/hpb_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
module hpb_mac_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_last_i,
  output logic tx_ready_o,
  output logic tx_done_o,
  output logic [7:0] tx_status_o,
  output logic rx_valid_o,
  output hpb_pkg::hpb_rx_word_t rx_word_o,
  input wire logic rx_ready_i
);
  logic [8:0] tx_got[$];
  hpb_pkg::hpb_rx_word_t rx_q[$];
  int done_cnt;
  int wait_cnt;
  logic [7:0] cyc;
  // ready drops every third cycle so the port must hold its byte
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cyc <= 8'h00;
      tx_ready_o <= 1'b0;
      tx_done_o <= 1'b0;
      tx_status_o <= 8'h00;
      rx_valid_o <= 1'b0;
      rx_word_o <= '0;
      done_cnt <= 0;
      wait_cnt <= 0;
    end else begin
      cyc <= cyc + 8'h01;
      tx_ready_o <= (cyc % 3) != 0;
      // long send time leaves room to load the next slot meanwhile
      tx_done_o <= (wait_cnt == 1);
      tx_status_o <= (wait_cnt == 1) ? 8'h81 + 8'(done_cnt) : ~cyc;
      if (wait_cnt == 1) done_cnt <= done_cnt + 1;
      if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
      if (tx_valid_i && tx_ready_o) begin
        tx_got.push_back({tx_last_i, tx_data_i});
        if (tx_last_i) wait_cnt <= 150;
      end
      if (rx_valid_o && rx_ready_i) void'(rx_q.pop_front());
      rx_valid_o <= rx_q.size() != 0;
      if (rx_q.size() != 0) rx_word_o <= rx_q[0];
      else rx_word_o <= {1'b0, cyc, ~cyc};
    end
  end
endmodule : hpb_mac_model
`default_nettype wire

//--- verification/test_host_packet_buffer_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_host_packet_buffer_port;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cs_pin_i = 1'b1;
  logic cs_pol_i = 1'b0;
  logic cmd_i = 1'b0;
  logic rd_n_i = 1'b1;
  logic wr_n_i = 1'b1;
  logic mode16_i = 1'b1;
  logic host_oe = 1'b0;
  logic [15:0] host_d = 16'h0000;
  logic [7:0] cyc = 8'h00;
  logic [15:0] sd_i, sd_o, q;
  logic sd_oe_o, rx_valid_i, rx_ready_o, tx_valid_o, tx_last_o, tx_ready_i, tx_done_i;
  logic [7:0] tx_data_o, tx_ctrl_o, tx_status_i;
  hpb_pkg::hpb_rx_word_t rx_word_i;
  int fails = 0;
  int total_checks = 0;
  // undriven bus floats: show a moving pattern, not a held value
  assign sd_i = host_oe ? host_d : (sd_oe_o ? sd_o : {cyc, ~cyc});
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 8'h01;
  hpb_host_port u_hpb_host_port (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_pin_i(cs_pin_i),
    .cs_pol_i(cs_pol_i), .cmd_i(cmd_i), .rd_n_i(rd_n_i), .wr_n_i(wr_n_i), .mode16_i(mode16_i),
    .sd_i(sd_i), .sd_o(sd_o), .sd_oe_o(sd_oe_o), .rx_valid_i(rx_valid_i),
    .rx_word_i(rx_word_i), .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o), .tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i),
    .tx_ctrl_o(tx_ctrl_o), .tx_done_i(tx_done_i), .tx_status_i(tx_status_i));
  hpb_mac_model u_hpb_mac_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .tx_valid_i(tx_valid_o),
    .tx_data_i(tx_data_o), .tx_last_i(tx_last_o), .tx_ready_o(tx_ready_i),
    .tx_done_o(tx_done_i), .tx_status_o(tx_status_i), .rx_valid_o(rx_valid_i),
    .rx_word_o(rx_word_i), .rx_ready_i(rx_ready_o));
  task automatic print_verdict;
    if (fails == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // strobe held 8 clocks, idle 7: the pin filter needs 4 each way
  task automatic bus(input logic c, input logic w, input logic s, input logic [15:0] d);
    @(posedge clk_i);
    cs_pin_i <= s ? cs_pol_i : ~cs_pol_i;
    cmd_i <= c;
    host_d <= d;
    host_oe <= w;
    rd_n_i <= w;
    wr_n_i <= ~w;
    repeat (8) @(posedge clk_i);
    q = sd_o;
    cmp({15'h0000, sd_oe_o}, {15'h0000, !w && s});
    rd_n_i <= 1'b1;
    wr_n_i <= 1'b1;
    cs_pin_i <= ~cs_pol_i;
    repeat (6) @(posedge clk_i);
    host_oe <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [15:0] v);
    bus(1'b0, 1'b1, 1'b1, {8'h00, idx});
    bus(1'b1, 1'b1, 1'b1, v);
  endtask : wr
  task automatic rd(input logic [7:0] idx);
    bus(1'b0, 1'b1, 1'b1, {8'h00, idx});
    bus(1'b1, 1'b0, 1'b1, 16'h0000);
  endtask : rd
  task automatic set_addr(input logic [15:0] a);
    wr(hpb_pkg::IDX_MADDR_LO, {8'h00, a[7:0]});
    wr(hpb_pkg::IDX_MADDR_HI, {8'h00, a[15:8]});
  endtask : set_addr
  task automatic set_mode(input logic m);
    @(posedge clk_i);
    mode16_i <= m;
    repeat (6) @(posedge clk_i);
  endtask : set_mode
  task automatic mem_wr(input logic [15:0] a, input logic [15:0] v[$]);
    set_addr(a);
    bus(1'b0, 1'b1, 1'b1, {8'h00, hpb_pkg::IDX_MEM_WR});
    foreach (v[i]) bus(1'b1, 1'b1, 1'b1, v[i]);
  endtask : mem_wr
  task automatic mem_chk(input logic [15:0] a, input logic [15:0] v[$]);
    set_addr(a);
    rd(hpb_pkg::IDX_MEM_RD);
    foreach (v[i]) begin
      bus(1'b1, 1'b0, 1'b1, 16'h0000);
      cmp(q, v[i]);
    end
  endtask : mem_chk
  task automatic wait_done(input int n);
    for (int i = 0; i < 3000 && u_hpb_mac_model.done_cnt != n; i++) @(posedge clk_i);
    if (u_hpb_mac_model.done_cnt != n) begin
      cmp(16'h0000, 16'h0001);
      print_verdict();
    end
  endtask : wait_done
  task automatic t_reset;
    cmp({8'h00, tx_ctrl_o}, 16'h0000);
    rd(hpb_pkg::IDX_RXPTR_LO);
    cmp(q, 16'h0000);
    rd(hpb_pkg::IDX_RXPTR_HI);
    cmp(q, 16'h000C);
    rd(hpb_pkg::IDX_IMR);
    cmp(q, 16'h0000);
  endtask : t_reset
  task automatic t_select;
    wr(hpb_pkg::IDX_IMR, 16'h0080);
    bus(1'b1, 1'b0, 1'b1, 16'h0000);
    cmp(q, 16'h0080);
    bus(1'b0, 1'b0, 1'b1, 16'h0000);
    cmp(q, 16'h00FE);
    bus(1'b0, 1'b1, 1'b0, {8'h00, hpb_pkg::IDX_TX_CTRL});
    bus(1'b1, 1'b1, 1'b0, 16'h0055);
    bus(1'b1, 1'b0, 1'b1, 16'h0000);
    cmp(q, 16'h0080);
    @(posedge clk_i);
    cs_pol_i <= 1'b1;
    cs_pin_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    wr(hpb_pkg::IDX_IMR, 16'h0000);
    bus(1'b1, 1'b0, 1'b1, 16'h0000);
    cmp(q, 16'h0000);
    cs_pol_i <= 1'b0;
    cs_pin_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    wr(hpb_pkg::IDX_IMR, 16'h0000);
  endtask : t_select
  task automatic t_mem;
    mem_wr(16'h0010, '{16'h1122, 16'h3344});
    mem_chk(16'h0010, '{16'h1122, 16'h3344});
    set_mode(1'b0);
    mem_chk(16'h0010, '{16'h0022, 16'h0011, 16'h0044, 16'h0033});
    mem_wr(16'h0020, '{16'h0055, 16'h0066});
    set_mode(1'b1);
    mem_chk(16'h0020, '{16'h6655});
  endtask : t_mem
  task automatic t_wrap;
    mem_wr(16'h0C00, '{16'hC0C1});
    mem_wr(16'h3FFE, '{16'hEEEF});
    wr(hpb_pkg::IDX_IMR, 16'h0080);
    mem_wr(16'h0BFE, '{16'hB0B1, 16'hA0A1});
    mem_chk(16'h0BFE, '{16'hB0B1, 16'hC0C1});
    mem_chk(16'h0000, '{16'hA0A1});
    mem_chk(16'h3FFE, '{16'hEEEF, 16'hC0C1});
    rd(hpb_pkg::IDX_MADDR_HI);
    cmp(q, 16'h000C);
    wr(hpb_pkg::IDX_IMR, 16'h0000);
  endtask : t_wrap
  task automatic t_tx;
    set_mode(1'b0);
    mem_wr(16'h0000, '{16'h0001, 16'h0002, 16'h0003});
    wr(hpb_pkg::IDX_TX_LEN_LO, 16'h0003);
    wr(hpb_pkg::IDX_TX_LEN_HI, 16'h0000);
    wr(hpb_pkg::IDX_TX_CTRL, 16'h0003);
    cmp({8'h00, tx_ctrl_o}, 16'h0003);
    mem_wr(16'h0003, '{16'h00A1, 16'h00A2});
    wait_done(1);
    cmp({7'h00, u_hpb_mac_model.tx_got[0]}, 16'h0001);
    cmp({7'h00, u_hpb_mac_model.tx_got[1]}, 16'h0002);
    cmp({7'h00, u_hpb_mac_model.tx_got[2]}, 16'h0103);
    rd(hpb_pkg::IDX_TX_STAT1);
    cmp(q, 16'h0081);
    rd(hpb_pkg::IDX_TX_CTRL);
    cmp(q, 16'h0001);
    wr(hpb_pkg::IDX_TX_LEN_LO, 16'h0002);
    rd(hpb_pkg::IDX_TX_LEN_LO);
    cmp(q, 16'h0002);
    wr(hpb_pkg::IDX_TX_CTRL, 16'h0003);
    wait_done(2);
    cmp({7'h00, u_hpb_mac_model.tx_got[3]}, 16'h00A1);
    cmp({7'h00, u_hpb_mac_model.tx_got[4]}, 16'h01A2);
    rd(hpb_pkg::IDX_TX_STAT2);
    cmp(q, 16'h0082);
    set_mode(1'b1);
  endtask : t_tx
  task automatic t_rx;
    int i;
    @(negedge clk_i);
    for (i = 0; i < 9; i++) u_hpb_mac_model.rx_q.push_back({i == 8, 8'h5A, 8'(8'h10 + i)});
    for (i = 0; i < 500 && u_hpb_mac_model.rx_q.size() != 0; i++) @(posedge clk_i);
    cmp(16'(u_hpb_mac_model.rx_q.size()), 16'h0000);
    if (u_hpb_mac_model.rx_q.size() != 0) print_verdict();
    // fifo drain plus header write
    repeat (16) @(posedge clk_i);
    cmp({15'h0000, rx_ready_o}, 16'h0001);
    rd(hpb_pkg::IDX_RXPTR_LO);
    cmp(q, 16'h000E);
    rd(hpb_pkg::IDX_RXPTR_HI);
    cmp(q, 16'h000C);
    mem_chk(16'h0C00, '{16'h5A01, 16'h0009, 16'h1110, 16'h1312});
  endtask : t_rx
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    t_reset();
    t_select();
    t_mem();
    t_wrap();
    t_tx();
    t_rx();
    print_verdict();
  end
endmodule : test_host_packet_buffer_port
`default_nettype wire
